// ===== common/flm_regs.vh
// Register offsets, field positions, reset values and timing counts of the FLL monitor.
//
// Notes on behaviour
// - Enter unlocked substate outside unlock window
// - Output halved until first lock
// - Unexpected relock keeps output undivided by two
// - Lock after consecutive samples inside lock window
// - Locked filter update averages four comparisons
// - Count DCO pulses, subtract multiply factor
// - Lock window to lock, unlock window to hold
// - Unexpected unlock sets sticky lock loss flag
// - Lock loss flag cleared by read-write sequence
// - Stop with enables low clears lock only
// - Keepalive dropped in stop flags lock loss
// - Factor, select, trim change clears lock only; the code clears lock on a trim change in FEI only
// - Monitored reference status means frequency met
// - Clock loss sets sticky flag, same clearing
// - Clock loss forces fallback mode, fields update
// - Engaged loss with reference good goes bypassed
// - Engaged clock loss also means lock loss
// - Monitoring follows mode and select
// - Off forces status low except crystal start-up
// - No DCO monitor until stable after entry
// - Select 11 engages when reference and DCO ready
`ifndef FLM_REGS_VH
`define FLM_REGS_VH

// Register word offsets (byte addresses).
`define FLM_CTRL_OFF 12'h000
`define FLM_MFD_OFF 12'h004
`define FLM_TRIM_OFF 12'h008
`define FLM_STAT_OFF 12'h00c

// Control register fields.
`define FLM_CTRL_REQ 0
`define FLM_CTRL_REF_TYPE_STATUS 2
`define FLM_CTRL_CLOCK_LOSS_DETECT_DISABLE 3
`define FLM_CTRL_LOCK_LOSS_RESET_EN 4
`define FLM_CTRL_CLOCK_LOSS_RESET_EN 5
`define FLM_CTRL_KEEP 6
`define FLM_CTRL_OSCST 7

// Status register fields.
`define FLM_STAT_LOCK 0
`define FLM_STAT_LOCK_LOSS_FLAG 1
`define FLM_STAT_CLOCK_LOSS_FLAG 2
`define FLM_STAT_EXT_REF_STATUS 3
`define FLM_STAT_DCO_STABLE_FLAG 4
`define FLM_STAT_IRQ 5
`define FLM_STAT_MODE 6

// Reset values.
`define FLM_CTRL_RST 8'h00
`define FLM_MFD_RST 8'h40
`define FLM_TRIM_RST 8'h80

// Mode codes as shown in the actual and requested mode fields.
`define FLM_MODE_SCM 2'h0
`define FLM_MODE_FEI 2'h1
`define FLM_MODE_FBE 2'h2
`define FLM_MODE_FEE 2'h3

// Output clock source selection codes.
`define FLM_OUT_DCO 2'h0
`define FLM_OUT_DCO_HALF 2'h1
`define FLM_OUT_EXT 2'h2
`define FLM_OUT_OFF 2'h3

// Timing counts: comparison window in pclk cycles, lock samples, and minimum edge counts per window.
`define FLM_COMP_CYCLES 16'd1024
`define FLM_LOCK_SAMPLES 4'd4
`define FLM_REF_MIN 12'd2
`define FLM_DCO_MIN 12'd8

`endif

// ===== core/flm_lock_det.v
// Lock detector with averaging loop filter update strobe.
`timescale 1ns/1ps
`include "flm_regs.vh"
module flm_lock_det #(
  parameter EW = 13,
  parameter signed [12:0] LOCK_MIN = -13'sd2,
  parameter signed [12:0] LOCK_MAX = 13'sd2,
  parameter signed [12:0] UNLOCK_MIN = -13'sd8,
  parameter signed [12:0] UNLOCK_MAX = 13'sd8,
  parameter [3:0] SAMPLES = `FLM_LOCK_SAMPLES
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Control.
  input wire enable,
  input wire clear,
  input wire sample,
  input wire signed [EW-1:0] err,
  // Results.
  output reg locked,
  output reg lost,
  output reg filt_upd,
  output reg signed [EW-1:0] filt_val
);
  reg [3:0] in_cnt;
  reg [1:0] avg_cnt;
  reg signed [EW+1:0] acc;
  wire in_lock = (err > LOCK_MIN) && (err < LOCK_MAX);
  wire in_unlock = (err >= UNLOCK_MIN) && (err <= UNLOCK_MAX);
  wire signed [EW+1:0] acc_next = acc + {{2{err[EW-1]}}, err};

  // Lock state, consecutive counter and filter strobes; expected clears never report a loss.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked <= 1'b0;
      lost <= 1'b0;
      filt_upd <= 1'b0;
      filt_val <= {EW{1'b0}};
      in_cnt <= 4'h0;
      avg_cnt <= 2'h0;
      acc <= {(EW+2){1'b0}};
    end else begin
      lost <= 1'b0;
      filt_upd <= 1'b0;
      if (!enable || clear) begin
        locked <= 1'b0;
        in_cnt <= 4'h0;
        avg_cnt <= 2'h0;
        acc <= {(EW+2){1'b0}};
      end else if (sample) begin
        if (!locked) begin
          filt_upd <= 1'b1;
          filt_val <= err;
          if (!in_lock) begin
            in_cnt <= 4'h0;
          end else if (in_cnt == SAMPLES - 4'h1) begin
            locked <= 1'b1;
            in_cnt <= 4'h0;
          end else begin
            in_cnt <= in_cnt + 4'h1;
          end
        end else if (!in_unlock) begin
          locked <= 1'b0;
          lost <= 1'b1;
          avg_cnt <= 2'h0;
          acc <= {(EW+2){1'b0}};
        end else if (avg_cnt == 2'h3) begin
          // Average of four by an arithmetic shift keeps the divider out of the datapath.
          filt_upd <= 1'b1;
          filt_val <= acc_next[EW+1:2];
          avg_cnt <= 2'h0;
          acc <= {(EW+2){1'b0}};
        end else begin
          avg_cnt <= avg_cnt + 2'h1;
          acc <= acc_next;
        end
      end
    end
  end
endmodule

// ===== core/flm_top.v
// FLL lock supervision, clock loss monitor and mode fallback with an APB register file.
`timescale 1ns/1ps
`include "flm_regs.vh"
module flm_top #(
  parameter [15:0] COMP_CYCLES = `FLM_COMP_CYCLES,
  parameter [11:0] REF_MIN = `FLM_REF_MIN,
  parameter [11:0] DCO_MIN = `FLM_DCO_MIN
) (
  // APB slave.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Clock pins sampled as levels.
  input wire dco_clock,
  input wire external_ref_clock,
  // System status from same-clock logic.
  input wire stop_mode,
  input wire osc_startup,
  input wire dco_stable_flag,
  // Results.
  output reg [1:0] mode_actual,
  output reg [1:0] gen_output_clock_sel,
  output reg gen_reset_req,
  output reg filter_update,
  output reg [12:0] filter_value
);
  localparam [4:0] S_OFF = 5'b00001;
  localparam [4:0] S_SCM = 5'b00010;
  localparam [4:0] S_FEI = 5'b00100;
  localparam [4:0] S_FBE = 5'b01000;
  localparam [4:0] S_FEE = 5'b10000;

  // Software registers.
  reg [1:0] mode_request;
  reg ref_type_status;
  reg clock_loss_detect_disable;
  reg lock_loss_reset_en;
  reg clock_loss_reset_en;
  reg debug_keepalive_en;
  reg stop_osc_en;
  reg [7:0] multiply_factor;
  reg [7:0] trim;
  reg lock_loss_flag;
  reg clock_loss_flag;
  reg clr_armed;

  // Monitor state.
  reg [4:0] state;
  reg [4:0] next_state;
  reg [1:0] next_req;
  reg force_req;
  reg [2:0] dco_sync;
  reg [2:0] ref_sync;
  reg [15:0] comp_cnt;
  reg comp_tick;
  reg samp;
  reg [11:0] dco_cnt;
  reg [11:0] ref_cnt;
  reg [11:0] dco_last;
  reg [11:0] ref_last;
  reg ref_ok;
  reg ext_ref_status;
  reg dco_mon_wait;
  reg out_halve;
  reg stop_d;
  reg wake_lol_pend;
  reg lock_clear;

  wire det_locked;
  wire det_lost;
  wire det_upd;
  wire [12:0] det_val;

  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire a_ctrl = ({paddr[11:2], 2'h0} == `FLM_CTRL_OFF);
  wire a_mfd = ({paddr[11:2], 2'h0} == `FLM_MFD_OFF);
  wire a_trim = ({paddr[11:2], 2'h0} == `FLM_TRIM_OFF);
  wire a_stat = ({paddr[11:2], 2'h0} == `FLM_STAT_OFF);
  wire mapped = a_ctrl || a_mfd || a_trim || a_stat;
  wire engaged = (state == S_FEI) || (state == S_FEE);
  wire signed [12:0] count_err = $signed({1'b0, dco_last}) - $signed({5'b0, multiply_factor});
  wire dco_edge = dco_sync[1] && !dco_sync[2];
  wire ref_edge = ref_sync[1] && !ref_sync[2];
  wire req_sel10 = (mode_request == `FLM_MODE_FBE);
  wire req_sel11 = (mode_request == `FLM_MODE_FEE);

  // Reference monitoring depends on mode, select and the crystal start-up window.
  wire ref_mon = !clock_loss_detect_disable &&
    ((state == S_OFF) ? (req_sel10 && ref_type_status && osc_startup) :
     (req_sel11 || (req_sel10 && ref_type_status)));
  // The DCO is watched in engaged and self-clocked modes once stable.
  wire dco_mon = !clock_loss_detect_disable &&
    (engaged || ((state == S_SCM) && !dco_mon_wait));
  wire ref_loss = samp && ref_mon && !ref_ok_now;
  wire dco_loss = samp && dco_mon && (dco_last < DCO_MIN);
  wire clk_loss = ref_loss || dco_loss;
  wire wake_lol = (state == S_OFF) && !stop_mode && wake_lol_pend;
  wire lol_evt = det_lost || (clk_loss && engaged) || wake_lol;
  wire stop_off = stop_mode && !debug_keepalive_en && !stop_osc_en;
  wire sw_clear = wr && a_stat && pwdata[`FLM_STAT_IRQ] && clr_armed;
  wire ref_ok_now = (ref_last >= REF_MIN);

  // Pin synchronisers: only the second stage reads the first.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dco_sync <= 3'h0;
      ref_sync <= 3'h0;
    end else begin
      dco_sync <= {dco_sync[1:0], dco_clock};
      ref_sync <= {ref_sync[1:0], external_ref_clock};
    end
  end

  // Comparison window: edges are counted, captured on the tick and compared one cycle later.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_cnt <= 16'h0;
      comp_tick <= 1'b0;
      samp <= 1'b0;
      dco_cnt <= 12'h0;
      ref_cnt <= 12'h0;
      dco_last <= 12'h0;
      ref_last <= 12'h0;
      ref_ok <= 1'b0;
    end else begin
      comp_tick <= (comp_cnt == COMP_CYCLES - 16'h1);
      comp_cnt <= (comp_cnt == COMP_CYCLES - 16'h1) ? 16'h0 : comp_cnt + 16'h1;
      samp <= comp_tick;
      if (comp_tick) begin
        dco_last <= dco_cnt;
        ref_last <= ref_cnt;
        dco_cnt <= {11'h0, dco_edge};
        ref_cnt <= {11'h0, ref_edge};
      end else begin
        // Saturating counts avoid a wrap reading as a slow clock.
        if (dco_edge && dco_cnt != 12'hfff) begin
          dco_cnt <= dco_cnt + 12'h1;
        end
        if (ref_edge && ref_cnt != 12'hfff) begin
          ref_cnt <= ref_cnt + 12'h1;
        end
      end
      if (samp) begin
        ref_ok <= ref_ok_now;
      end
    end
  end

  // Reference status: real time when monitored, forced otherwise.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_ref_status <= 1'b0;
    end else if (ref_mon) begin
      ext_ref_status <= samp ? ref_ok_now : ref_ok;
    end else begin
      ext_ref_status <= (state != S_OFF) && req_sel10 && !ref_type_status;
    end
  end

  // Mode selection, including forced fallbacks that rewrite the requested mode.
  always @* begin
    next_state = state;
    next_req = mode_request;
    force_req = 1'b0;
    case (state)
      S_OFF: begin
        if (!stop_mode) begin
          next_state = (req_sel10 && ext_ref_status) ? S_FBE : S_SCM;
        end
      end
      S_SCM: begin
        if (stop_off) begin
          next_state = S_OFF;
        end else if (mode_request == `FLM_MODE_FEI && dco_stable_flag) begin
          next_state = S_FEI;
        end else if (req_sel11 && ext_ref_status && dco_stable_flag) begin
          next_state = S_FEE;
        end else if (req_sel10 && ext_ref_status) begin
          next_state = S_FBE;
        end
      end
      S_FEI: begin
        if (stop_off) begin
          next_state = S_OFF;
        end else if (mode_request == `FLM_MODE_SCM || req_sel10) begin
          next_state = S_SCM;
        end else if (req_sel11 && ext_ref_status && dco_stable_flag) begin
          next_state = S_FEE;
        end
      end
      S_FBE: begin
        if (stop_off) begin
          next_state = S_OFF;
        end else if (ref_loss) begin
          next_state = S_SCM;
          next_req = `FLM_MODE_SCM;
          force_req = 1'b1;
        end else if (!req_sel10) begin
          next_state = S_SCM;
        end
      end
      S_FEE: begin
        if (stop_off) begin
          next_state = S_OFF;
        end else if (ref_loss) begin
          next_state = S_SCM;
          next_req = `FLM_MODE_SCM;
          force_req = 1'b1;
        end else if (dco_loss && ext_ref_status) begin
          next_state = S_FBE;
          next_req = `FLM_MODE_FBE;
          force_req = 1'b1;
        end else if (!req_sel11) begin
          next_state = (req_sel10 && ext_ref_status) ? S_FBE : S_SCM;
        end
      end
      default: begin
        next_state = S_SCM;
      end
    endcase
  end

  // State, DCO monitor hold-off and stop bookkeeping.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_SCM;
      dco_mon_wait <= 1'b0;
      stop_d <= 1'b0;
      wake_lol_pend <= 1'b0;
    end else begin
      state <= next_state;
      stop_d <= stop_mode;
      if (next_state == S_SCM && (state == S_OFF || state == S_FBE)) begin
        dco_mon_wait <= 1'b1;
      end else if (dco_stable_flag) begin
        dco_mon_wait <= 1'b0;
      end
      // Keepalive dropped after the stop began is an unexpected clock stop.
      if (state != S_OFF && next_state == S_OFF && stop_d) begin
        wake_lol_pend <= 1'b1;
      end else if (wake_lol) begin
        wake_lol_pend <= 1'b0;
      end
    end
  end

  // Software registers; a forced fallback overrides a write to the select field.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {stop_osc_en, debug_keepalive_en, clock_loss_reset_en, lock_loss_reset_en,
       clock_loss_detect_disable, ref_type_status, mode_request} <= `FLM_CTRL_RST;
      multiply_factor <= `FLM_MFD_RST;
      trim <= `FLM_TRIM_RST;
      lock_clear <= 1'b0;
    end else begin
      lock_clear <= 1'b0;
      if (wr && a_ctrl) begin
        {stop_osc_en, debug_keepalive_en, clock_loss_reset_en, lock_loss_reset_en,
         clock_loss_detect_disable, ref_type_status} <= pwdata[7:2];
        mode_request <= pwdata[`FLM_CTRL_REQ +: 2];
        if (pwdata[`FLM_CTRL_REQ +: 2] != mode_request) begin
          lock_clear <= 1'b1;
        end
      end
      if (force_req) begin
        mode_request <= next_req;
      end
      if (wr && a_mfd) begin
        multiply_factor <= pwdata[7:0];
        lock_clear <= lock_clear || (pwdata[7:0] != multiply_factor);
      end
      if (wr && a_trim) begin
        trim <= pwdata[7:0];
        if (state == S_FEI && pwdata[7:0] != trim) begin
          lock_clear <= 1'b1;
        end
      end
      if (next_state != state) begin
        lock_clear <= 1'b1;
      end
    end
  end

  // Sticky error flags: a new event in the clearing cycle wins over the clear.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_loss_flag <= 1'b0;
      clock_loss_flag <= 1'b0;
      clr_armed <= 1'b0;
      gen_reset_req <= 1'b0;
    end else begin
      if (lol_evt) begin
        lock_loss_flag <= 1'b1;
      end else if (sw_clear) begin
        lock_loss_flag <= 1'b0;
      end
      if (clk_loss) begin
        clock_loss_flag <= 1'b1;
      end else if (sw_clear) begin
        clock_loss_flag <= 1'b0;
      end
      if (rd && a_stat) begin
        clr_armed <= 1'b1;
      end else if (wr && a_stat) begin
        clr_armed <= 1'b0;
      end
      // The lock-loss reset request wins even when the clock-loss reset is off.
      gen_reset_req <= (lol_evt && lock_loss_reset_en) || (clk_loss && clock_loss_reset_en);
    end
  end

  // Output clock routing; the halving holds from engaged-external entry until first lock.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_halve <= 1'b0;
      gen_output_clock_sel <= `FLM_OUT_DCO;
      mode_actual <= `FLM_MODE_SCM;
    end else begin
      if ((next_state == S_FEE && state != S_FEE) || (state == S_FEE && lock_clear)) begin
        out_halve <= 1'b1;
      end else if (det_locked || state != S_FEE) begin
        out_halve <= 1'b0;
      end
      if (state == S_OFF || (stop_mode && !debug_keepalive_en)) begin
        gen_output_clock_sel <= `FLM_OUT_OFF;
      end else if (state == S_FBE) begin
        gen_output_clock_sel <= `FLM_OUT_EXT;
      end else if (state == S_FEE && out_halve) begin
        gen_output_clock_sel <= `FLM_OUT_DCO_HALF;
      end else begin
        gen_output_clock_sel <= `FLM_OUT_DCO;
      end
      // Off keeps the last code shown since it has no code of its own.
      case (state)
        S_SCM: mode_actual <= `FLM_MODE_SCM;
        S_FEI: mode_actual <= `FLM_MODE_FEI;
        S_FBE: mode_actual <= `FLM_MODE_FBE;
        S_FEE: mode_actual <= `FLM_MODE_FEE;
        default: mode_actual <= mode_actual;
      endcase
    end
  end

  // Lock detector runs only while the loop is closed.
  flm_lock_det #(
    .EW(13),
    .SAMPLES(`FLM_LOCK_SAMPLES)
  ) u_det (
    .pclk(pclk),
    .presetn(presetn),
    .enable(engaged),
    .clear(lock_clear),
    .sample(samp),
    .err(count_err),
    .locked(det_locked),
    .lost(det_lost),
    .filt_upd(det_upd),
    .filt_val(det_val)
  );

  // Filter strobe retimed so the port comes straight from a flop.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_update <= 1'b0;
      filter_value <= 13'h0;
    end else begin
      filter_update <= det_upd;
      if (det_upd) begin
        filter_value <= det_val;
      end
    end
  end

  // APB answer: zero wait states, unmapped addresses flag an error and read zero.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        if (a_ctrl) begin
          prdata <= {24'h0, stop_osc_en, debug_keepalive_en, clock_loss_reset_en, lock_loss_reset_en,
                     clock_loss_detect_disable, ref_type_status, mode_request};
        end else if (a_mfd) begin
          prdata <= {24'h0, multiply_factor};
        end else if (a_trim) begin
          prdata <= {24'h0, trim};
        end else if (a_stat) begin
          prdata <= {24'h0, mode_actual, lock_loss_flag || clock_loss_flag, dco_stable_flag,
                     ext_ref_status, clock_loss_flag, lock_loss_flag, det_locked};
        end
      end
    end
  end
endmodule

// ===== verif/fll_lock_and_clock_loss_monitor_bench.sv
// Self-checking bench for the FLL lock and clock loss monitor.
`timescale 1ns/1ps
`include "flm_regs.vh"
module fll_lock_and_clock_loss_monitor_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic stop_mode, osc_startup, dco_stable_flag, dco_run, ref_run, dco_clock, external_ref_clock;
  logic [3:0] dco_half;
  logic [1:0] mode_actual, gen_output_clock_sel;
  logic gen_reset_req, filter_update;
  logic [12:0] filter_value;
  int failures, cmp_count, resets_seen;

  // A short comparison window keeps each lock attempt to a few hundred cycles.
  flm_top #(.COMP_CYCLES(16'd64)) i_flm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dco_clock(dco_clock), .external_ref_clock(external_ref_clock), .stop_mode(stop_mode),
    .osc_startup(osc_startup), .dco_stable_flag(dco_stable_flag), .mode_actual(mode_actual),
    .gen_output_clock_sel(gen_output_clock_sel), .gen_reset_req(gen_reset_req),
    .filter_update(filter_update), .filter_value(filter_value));
  flm_clk_src i_flm_clk_src (.pclk(pclk), .run(dco_run), .half(dco_half), .clk_out(dco_clock));
  flm_clk_src i_flm_clk_src_ref (.pclk(pclk), .run(ref_run), .half(4'h4), .clk_out(external_ref_clock));

  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Count reset requests so a one-cycle pulse is never missed.
  always @(posedge pclk) if (gen_reset_req === 1'b1) resets_seen <= resets_seen + 1;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wait_stat(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, `FLM_STAT_OFF, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 300);
    if (rd[b] !== 1'b1) begin
      failures++;
      complete_run;
    end
  endtask

  task wait_mode(input logic [1:0] m);
    int n;
    n = 0;
    while (mode_actual !== m && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (mode_actual !== m) begin
      failures++;
      complete_run;
    end
    repeat (3) @(posedge pclk);
  endtask

  task clear_flags;
    apb(1'b0, `FLM_STAT_OFF, 32'h0);
    apb(1'b1, `FLM_STAT_OFF, 32'h20);
  endtask

  task t_reset_values;
    chk(mode_actual, `FLM_MODE_SCM);
    apb(1'b0, `FLM_CTRL_OFF, 32'h0);
    chk(rd, `FLM_CTRL_RST);
    apb(1'b0, `FLM_MFD_OFF, 32'h0);
    chk(rd, `FLM_MFD_RST);
    apb(1'b0, `FLM_TRIM_OFF, 32'h0);
    chk(rd, `FLM_TRIM_RST);
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1);
  endtask

  task t_engage;
    apb(1'b1, `FLM_MFD_OFF, 32'h10);
    apb(1'b1, `FLM_CTRL_OFF, 32'h3);
    wait_mode(`FLM_MODE_FEE);
    chk(mode_actual, `FLM_MODE_FEE);
    chk(gen_output_clock_sel, `FLM_OUT_DCO_HALF);
    wait_stat(`FLM_STAT_LOCK);
    chk(rd[2:0], 3'h1);
    chk(gen_output_clock_sel, `FLM_OUT_DCO);
  endtask

  // Too many DCO edges pushes the error out of the unlock window.
  task t_lock_loss;
    dco_half <= 4'h1;
    wait_stat(`FLM_STAT_LOCK_LOSS_FLAG);
    chk(rd[2:0], 3'h2);
    chk(gen_output_clock_sel, `FLM_OUT_DCO);
    dco_half <= 4'h2;
    apb(1'b1, `FLM_STAT_OFF, 32'h0);
    apb(1'b1, `FLM_STAT_OFF, 32'h20);
    apb(1'b0, `FLM_STAT_OFF, 32'h0);
    chk(rd[1], 1'b1);
    apb(1'b1, `FLM_STAT_OFF, 32'h20);
    apb(1'b0, `FLM_STAT_OFF, 32'h0);
    chk(rd[1], 1'b0);
    wait_stat(`FLM_STAT_LOCK);
  endtask

  task t_factor_change;
    apb(1'b1, `FLM_MFD_OFF, 32'h11);
    apb(1'b0, `FLM_STAT_OFF, 32'h0);
    chk(rd[1:0], 2'h0);
    chk(gen_output_clock_sel, `FLM_OUT_DCO_HALF);
    wait_stat(`FLM_STAT_LOCK);
    chk(rd[1:0], 2'h1);
    chk(filter_value, 13'h1fff);
  endtask

  task t_dco_loss;
    dco_run <= 1'b0;
    wait_mode(`FLM_MODE_FBE);
    chk(mode_actual, `FLM_MODE_FBE);
    chk(gen_output_clock_sel, `FLM_OUT_EXT);
    apb(1'b0, `FLM_STAT_OFF, 32'h0);
    chk(rd[2:1], 2'h3);
    apb(1'b0, `FLM_CTRL_OFF, 32'h0);
    chk(rd[1:0], `FLM_MODE_FBE);
    clear_flags;
    apb(1'b0, `FLM_STAT_OFF, 32'h0);
    chk(rd[2:1], 2'h0);
  endtask

  // With only the lock-loss reset armed, the reset request must come out.
  task t_ref_loss;
    dco_run <= 1'b1;
    // Two full windows let the DCO count recover before it is watched again.
    repeat (140) @(posedge pclk);
    apb(1'b1, `FLM_CTRL_OFF, 32'h13);
    wait_mode(`FLM_MODE_FEE);
    wait_stat(`FLM_STAT_LOCK);
    chk(resets_seen, 0);
    ref_run <= 1'b0;
    wait_mode(`FLM_MODE_SCM);
    chk(mode_actual, `FLM_MODE_SCM);
    chk(resets_seen > 0, 1'b1);
  endtask

  // An expected stop turns the output off but never flags a lock loss.
  task t_stop;
    clear_flags;
    stop_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(gen_output_clock_sel, `FLM_OUT_OFF);
    stop_mode <= 1'b0;
    wait_mode(`FLM_MODE_SCM);
    apb(1'b0, `FLM_STAT_OFF, 32'h0);
    chk(rd[1], 1'b0);
  endtask

  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence after a twelve-cycle reset.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    stop_mode = 1'b0;
    osc_startup = 1'b0;
    dco_stable_flag = 1'b1;
    dco_half = 4'h2;
    dco_run = 1'b1;
    ref_run = 1'b1;
    failures = 0;
    cmp_count = 0;
    resets_seen = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_values;
    t_engage;
    t_lock_loss;
    t_factor_change;
    t_dco_loss;
    t_ref_loss;
    t_stop;
    complete_run;
  end

  // The whole run needs well under 20000 cycles; this catches a hang.
  initial begin
    #300000;
    failures++;
    complete_run;
  end
endmodule

// ===== verif/flm_clk_src.sv
// Behavioural clock source standing in for the crystal or DCO pin.
`timescale 1ns/1ps
module flm_clk_src (
  // Bus clock that paces the toggling.
  input wire pclk,
  // Control from the bench.
  input wire run,
  input wire [3:0] half,
  // Generated clock level.
  output logic clk_out
);
  logic [3:0] cnt;

  // Start parked low so the pin is never unknown.
  initial begin
    cnt = 4'h0;
    clk_out = 1'b0;
  end

  // A stopped source parks low, so a dead clock shows no edges at all.
  always @(posedge pclk) begin
    if (!run) begin
      cnt <= 4'h0;
      clk_out <= 1'b0;
    end else if (cnt + 4'h1 >= half) begin
      cnt <= 4'h0;
      clk_out <= ~clk_out;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// ===== verif/flm_top_properties.sv
// Port-level checks of the FLL lock and clock loss monitor.
`timescale 1ns/1ps
module flm_top_checker (
  // Clock, reset and bus.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Status inputs and results.
  input wire dco_stable_flag,
  input wire stop_mode,
  input wire [1:0] mode_actual,
  input wire [1:0] gen_output_clock_sel,
  input wire gen_reset_req,
  input wire filter_update,
  input wire [12:0] filter_value
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_halve_engaged;
    gen_output_clock_sel == 2'h1 |-> mode_actual == 2'h3 || $past(mode_actual) == 2'h3;
  endproperty
  a_halve_engaged: assert property (p_halve_engaged) else $error("halved output outside engaged mode");

  property p_bypass_ext;
    mode_actual == 2'h2 && $past(mode_actual, 2) == 2'h2 && !stop_mode && !$past(stop_mode, 2)
      |-> gen_output_clock_sel == 2'h2;
  endproperty
  a_bypass_ext: assert property (p_bypass_ext) else $error("bypassed mode not on reference");

  property p_engage_ready;
    mode_actual == 2'h3 && $past(mode_actual) != 2'h3 |-> $past(dco_stable_flag, 2);
  endproperty
  a_engage_ready: assert property (p_engage_ready) else $error("engaged without stable DCO");

  property p_reset_pulse;
    gen_reset_req |=> !gen_reset_req;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset request longer than a cycle");

  property p_filt_spacing;
    filter_update |=> !filter_update [*8];
  endproperty
  a_filt_spacing: assert property (p_filt_spacing) else $error("filter updates too close");

  property p_filt_hold;
    !filter_update |-> $stable(filter_value);
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter value moved without update");

  property p_ready_after_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready in access cycle");

  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
endmodule

bind flm_top flm_top_checker i_flm_top_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dco_stable_flag(dco_stable_flag),
  .stop_mode(stop_mode), .mode_actual(mode_actual), .gen_output_clock_sel(gen_output_clock_sel),
  .gen_reset_req(gen_reset_req), .filter_update(filter_update), .filter_value(filter_value));
